// *** verilog/gpo_port.sv ***
// gpo_port: two 8-pin ports with alternate-function overrides, AXI4-Lite registers
`timescale 1ns/1ps
module gpo_port
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleepClamp,
  input wire gpo_pkg::gpo_ovr_t [15:0] pinOverride,
  input wire logic [15:0] extIntEnable,
  input wire gpo_pkg::gpo_sense_t [15:0] extIntSense,
  input wire logic [15:0] padIn,
  output logic [15:0] padOut,
  output logic [15:0] padOe,
  output logic [15:0] padPullup,
  output logic [15:0] altfuncRawInput,
  output logic [15:0] wakeFlag,
  output logic irq
);
  localparam int NP = gpo_pkg::NPINS * gpo_pkg::NPORTS;
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NP-1:0] dirBits;
    logic [NP-1:0] outBits;
    logic [7:0] mcuControl;
    logic [7:0] portControl;
    logic [NP-1:0] irqStatus;
    logic [NP-1:0] irqMask;
    logic [NP-1:0] clampSeen;
    logic sleepDly;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    gpo_pkg::gpo_bus_st_t wrSt;
    logic [1:0] bresp;
    gpo_pkg::gpo_bus_st_t rdSt;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gpo_st_t;
  gpo_st_t st;
  gpo_st_t next_st;
  logic [NP-1:0] pinInput;
  logic [NP-1:0] inputEnable;
  logic [NP-1:0] pudTerm;
  logic [NP-1:0] oeRes;
  logic [NP-1:0] pullRes;
  logic [NP-1:0] togMask;
  logic [NP-1:0] schmittOut;
  logic [NP-1:0] wakeEvents;

  // word at an address, zero-extended; unmapped reads answer zero
  function automatic logic [31:0] readWord(input gpo_st_t s, input logic [7:0] a, input logic [NP-1:0] pin);
    logic [31:0] w;
    w = '0;
    case (a)
      gpo_pkg::ADDR_DIR_A: w[7:0] = s.dirBits[7:0];
      gpo_pkg::ADDR_OUT_A: w[7:0] = s.outBits[7:0];
      gpo_pkg::ADDR_IN_A: w[7:0] = pin[7:0];
      gpo_pkg::ADDR_DIR_B: w[7:0] = s.dirBits[15:8];
      gpo_pkg::ADDR_OUT_B: w[7:0] = s.outBits[15:8];
      gpo_pkg::ADDR_IN_B: w[7:0] = pin[15:8];
      gpo_pkg::ADDR_MCU_CONTROL: w[7:0] = s.mcuControl;
      gpo_pkg::ADDR_PORT_CONTROL: w[7:0] = s.portControl;
      gpo_pkg::ADDR_IRQ_STATUS: w[15:0] = s.irqStatus;
      gpo_pkg::ADDR_IRQ_MASK: w[15:0] = s.irqMask;
      default: w = '0;
    endcase
    return w;
  endfunction

  function automatic logic addrMapped(input logic [7:0] a);
    return a == gpo_pkg::ADDR_DIR_A || a == gpo_pkg::ADDR_OUT_A || a == gpo_pkg::ADDR_IN_A
      || a == gpo_pkg::ADDR_DIR_B || a == gpo_pkg::ADDR_OUT_B || a == gpo_pkg::ADDR_IN_B
      || a == gpo_pkg::ADDR_MCU_CONTROL || a == gpo_pkg::ADDR_PORT_CONTROL
      || a == gpo_pkg::ADDR_IRQ_STATUS || a == gpo_pkg::ADDR_IRQ_MASK;
  endfunction

  // ****************************************
  // pin resolution
  // ****************************************
  gpo_sync u_sync
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .rawIn(schmittOut),
    .syncOut(pinInput)
  );

  always_comb
  begin
    for (int i = 0; i < NP; i++)
    begin
      // port disable ORed with global bit 4
      pudTerm[i] = st.portControl[i / gpo_pkg::NPINS] | st.mcuControl[gpo_pkg::GPUD_BIT];
      // clamp in sleep unless enabled as external interrupt
      inputEnable[i] = pinOverride[i].input_enable_override_en ? pinOverride[i].input_enable_override_val
        : (!sleepClamp || extIntEnable[i]);
      // raw input is ahead of the synchroniser
      schmittOut[i] = padIn[i] & inputEnable[i];
      oeRes[i] = pinOverride[i].direction_override_en ? pinOverride[i].direction_override_val
        : st.dirBits[i];
      pullRes[i] = pinOverride[i].pullup_override_en ? pinOverride[i].pullup_override_val
        : (!st.dirBits[i] && st.outBits[i] && !pudTerm[i]);
      // only drive while enabled; otherwise level is forced low with oe low
      padOut[i] = oeRes[i] & (pinOverride[i].outvalue_override_en ? pinOverride[i].outvalue_override_val
        : st.outBits[i]);
      togMask[i] = pinOverride[i].output_toggle_override;
      // clamped low input on a high pin reads as a change at wake
      wakeEvents[i] = st.sleepDly && !sleepClamp && st.clampSeen[i]
        && extIntSense[i] != gpo_pkg::SENSE_LOW;
    end
  end

  assign padOe = oeRes;
  assign padPullup = nrst ? pullRes : '0; // pull-ups off throughout reset
  assign altfuncRawInput = schmittOut;
  // analog path is the pad itself, no gate in this block

  // ****************************************
  // registers and bus
  // ****************************************
  always_comb
  begin
    logic [NP-1:0] tog;
    logic [NP-1:0] clr;
    logic [31:0] wd;
    next_st = st;
    tog = togMask;
    clr = '0;
    wd = '0;
    next_st.sleepDly = sleepClamp;
    for (int i = 0; i < NP; i++)
    begin
      if (sleepClamp && !inputEnable[i] && !extIntEnable[i])
      begin
        next_st.clampSeen[i] = padIn[i];
      end
      else if (!sleepClamp)
      begin
        next_st.clampSeen[i] = 1'b0;
      end
    end
    if (s_axi_awvalid && !st.awHeld && st.wrSt == gpo_pkg::BUS_IDLE)
    begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wHeld && st.wrSt == gpo_pkg::BUS_IDLE)
    begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    case (st.wrSt)
      gpo_pkg::BUS_IDLE:
      begin
        if (st.awHeld && st.wHeld)
        begin
          wd = st.wStrb[0] ? st.wData : '0;
          case (st.awAddr)
            gpo_pkg::ADDR_DIR_A: if (st.wStrb[0]) next_st.dirBits[7:0] = wd[7:0];
            gpo_pkg::ADDR_OUT_A: if (st.wStrb[0]) next_st.outBits[7:0] = wd[7:0];
            gpo_pkg::ADDR_IN_A: tog[7:0] = tog[7:0] ^ wd[7:0];
            gpo_pkg::ADDR_DIR_B: if (st.wStrb[0]) next_st.dirBits[15:8] = wd[7:0];
            gpo_pkg::ADDR_OUT_B: if (st.wStrb[0]) next_st.outBits[15:8] = wd[7:0];
            gpo_pkg::ADDR_IN_B: tog[15:8] = tog[15:8] ^ wd[7:0];
            gpo_pkg::ADDR_MCU_CONTROL: if (st.wStrb[0]) next_st.mcuControl = wd[7:0];
            gpo_pkg::ADDR_PORT_CONTROL: if (st.wStrb[0]) next_st.portControl = wd[7:0];
            gpo_pkg::ADDR_IRQ_STATUS: clr = {st.wStrb[1] ? st.wData[15:8] : 8'h00, wd[7:0]};
            gpo_pkg::ADDR_IRQ_MASK:
            begin
              if (st.wStrb[0]) next_st.irqMask[7:0] = st.wData[7:0];
              if (st.wStrb[1]) next_st.irqMask[15:8] = st.wData[15:8];
            end
            default: wd = '0;
          endcase
          next_st.bresp = addrMapped(st.awAddr) ? gpo_pkg::RESP_OKAY : gpo_pkg::RESP_SLVERR;
          next_st.awHeld = 1'b0;
          next_st.wHeld = 1'b0;
          next_st.wrSt = gpo_pkg::BUS_RESP;
        end
      end
      gpo_pkg::BUS_RESP:
      begin
        if (s_axi_bready)
        begin
          next_st.wrSt = gpo_pkg::BUS_IDLE;
        end
      end
      default: next_st.wrSt = gpo_pkg::BUS_IDLE;
    endcase
    next_st.outBits = next_st.outBits ^ tog;
    // set wins over a same-cycle write-one clear
    next_st.irqStatus = (st.irqStatus & ~clr) | wakeEvents;
    case (st.rdSt)
      gpo_pkg::BUS_IDLE:
      begin
        if (s_axi_arvalid)
        begin
          next_st.rdata = readWord(st, s_axi_araddr, pinInput);
          next_st.rresp = addrMapped(s_axi_araddr) ? gpo_pkg::RESP_OKAY : gpo_pkg::RESP_SLVERR;
          next_st.rdSt = gpo_pkg::BUS_RESP;
        end
      end
      gpo_pkg::BUS_RESP:
      begin
        if (s_axi_rready)
        begin
          next_st.rdSt = gpo_pkg::BUS_IDLE;
        end
      end
      default: next_st.rdSt = gpo_pkg::BUS_IDLE;
    endcase
    if (!nrst)
    begin
      next_st = '0; // direction and output cleared, so pins float after reset
    end
  end

  always_ff @(posedge ref_clk)
  begin
    st <= next_st;
  end

  assign s_axi_awready = !st.awHeld && st.wrSt == gpo_pkg::BUS_IDLE;
  assign s_axi_wready = !st.wHeld && st.wrSt == gpo_pkg::BUS_IDLE;
  assign s_axi_bvalid = st.wrSt == gpo_pkg::BUS_RESP;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.rdSt == gpo_pkg::BUS_IDLE;
  assign s_axi_rvalid = st.rdSt == gpo_pkg::BUS_RESP;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign wakeFlag = st.irqStatus;
  assign irq = |(st.irqStatus & st.irqMask);

  // ****************************************
  // checks
  // ****************************************
  // properties watch pins that the bench exercises; every pin shares the same logic
  property pOe;
    @(posedge ref_clk) disable iff (!nrst)
    pinOverride[1].direction_override_en |-> padOe[1] == pinOverride[1].direction_override_val;
  endproperty
  dir_override_a: assert property (pOe) else $error("oe ignores override");
  pull_reset_a: assert property (@(posedge ref_clk) !nrst |-> padPullup == '0)
    else $error("pull-up on in reset");
  pull_gpud_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    st.mcuControl[gpo_pkg::GPUD_BIT] && !pinOverride[0].pullup_override_en |-> !padPullup[0])
    else $error("global disable ignored");
  pull_formula_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pinOverride[0].pullup_override_en && !st.dirBits[0] && st.outBits[0] && !st.portControl[0]
    && !st.mcuControl[gpo_pkg::GPUD_BIT] |-> padPullup[0])
    else $error("pull-up missing");
  clamp_sleep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sleepClamp && !extIntEnable[2] && !pinOverride[2].input_enable_override_en |-> !altfuncRawInput[2])
    else $error("input not clamped");
  clamp_bypass_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    extIntEnable[0] && !pinOverride[0].input_enable_override_en |-> altfuncRawInput[0] == padIn[0])
    else $error("interrupt pin clamped");
  ie_override_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    pinOverride[0].input_enable_override_en |-> altfuncRawInput[0] == (padIn[0] && pinOverride[0].input_enable_override_val))
    else $error("input enable override ignored");
  drive_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    padOe[3] && pinOverride[3].outvalue_override_en |-> padOut[3] == pinOverride[3].outvalue_override_val)
    else $error("override value not driven");
  toggle_ovr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    pinOverride[2].output_toggle_override && !(st.awHeld && st.wHeld)
    |=> st.outBits[2] != $past(st.outBits[2]))
    else $error("toggle lost");
  // reset clears the synchroniser, so only inputs taken after release can be compared
  sync_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $past(nrst) && $past(nrst, 2) |-> pinInput == $past(schmittOut, 2))
    else $error("synchroniser depth wrong");
  float_pad_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !pinOverride[6].direction_override_en && !pinOverride[6].pullup_override_en
    && !st.dirBits[6] && !st.outBits[6] |-> !padOe[6] && !padPullup[6] && !padOut[6])
    else $error("pad driven when off");
  // clamped high pin with sensing on, then the sleep ends
  sequence sClampedHigh;
    sleepClamp && !extIntEnable[0] && !pinOverride[0].input_enable_override_en && padIn[0]
      && extIntSense[0] != gpo_pkg::SENSE_LOW;
  endsequence
  sequence sWake;
    !sleepClamp;
  endsequence
  wake_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    sClampedHigh ##1 sWake |=> wakeFlag[0])
    else $error("wake flag not set");
endmodule // gpo_port

// *** verilog/gpo_pkg.sv ***
// gpo_pkg: constants, types and register map of the pin override port block
// Behaviour
// - power-down/save sleep clamps digital inputs low
// - enabled external interrupt pin bypasses clamp
// - clamped high pin sets flag on wake unless its sense is low level
// - pull-ups forced off during reset
// - pull-up override, else dir/out/disable 0,1,0
// - direction override value drives output enable
// - driven level from override value or output
// - toggle override inverts the output bit
// - input-enable override beats sleep state
// - raw input taken before port synchroniser
// - analog path straight to pad, ungated
// - global pull-up disable is control bit 4
// - strobes per port, sleep/disable shared, overrides per pin
// - direction one drives, zero selects pull-up
// - port and global pull-up disables ORed
// - writing one to input bit toggles output
package gpo_pkg;
  localparam int NPINS = 8;
  localparam int NPORTS = 2;
  localparam int AW = 8;
  // byte addresses of the register words
  localparam logic [AW-1:0] ADDR_DIR_A = 8'h00;
  localparam logic [AW-1:0] ADDR_OUT_A = 8'h04;
  localparam logic [AW-1:0] ADDR_IN_A = 8'h08;
  localparam logic [AW-1:0] ADDR_DIR_B = 8'h0C;
  localparam logic [AW-1:0] ADDR_OUT_B = 8'h10;
  localparam logic [AW-1:0] ADDR_IN_B = 8'h14;
  localparam logic [AW-1:0] ADDR_MCU_CONTROL = 8'h18;
  localparam logic [AW-1:0] ADDR_PORT_CONTROL = 8'h1C;
  localparam logic [AW-1:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 8'h24;
  localparam int GPUD_BIT = 4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // per-pin override group from one alternate-function module
  typedef struct packed {
    logic pullup_override_en;
    logic pullup_override_val;
    logic direction_override_en;
    logic direction_override_val;
    logic outvalue_override_en;
    logic outvalue_override_val;
    logic output_toggle_override;
    logic input_enable_override_en;
    logic input_enable_override_val;
  } gpo_ovr_t;
  typedef enum logic [1:0] {SENSE_LOW, SENSE_ANY, SENSE_FALL, SENSE_RISE} gpo_sense_t;
  typedef enum logic {BUS_IDLE, BUS_RESP} gpo_bus_st_t;
endpackage

// *** verilog/gpo_sync.sv ***
// gpo_sync: two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
module gpo_sync
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [gpo_pkg::NPINS*gpo_pkg::NPORTS-1:0] rawIn,
  output logic [gpo_pkg::NPINS*gpo_pkg::NPORTS-1:0] syncOut
);
  typedef struct packed {
    logic [gpo_pkg::NPINS*gpo_pkg::NPORTS-1:0] meta;
    logic [gpo_pkg::NPINS*gpo_pkg::NPORTS-1:0] stable;
  } gpo_sync_st_t;
  gpo_sync_st_t st;
  gpo_sync_st_t next_st;
  always_comb
  begin
    next_st.meta = rawIn;
    next_st.stable = st.meta;
    if (!nrst)
    begin
      next_st = '0;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    st <= next_st;
  end
  assign syncOut = st.stable;
endmodule // gpo_sync

// *** verification/gpo_pad_model.sv ***
// gpo_pad_model: behavioural model of the circuitry at the package pins
`timescale 1ns/1ps
module gpo_pad_model
(
  input wire logic ref_clk,
  input wire logic [15:0] padOut,
  input wire logic [15:0] padOe,
  input wire logic [15:0] padPullup,
  output logic [15:0] padIn
);
  // undriven pads wander every cycle so a stale level never passes for a real one
  logic [15:0] wander = 16'h0000;
  always @(posedge ref_clk)
    wander <= ~wander;
  always_comb
    for (int i = 0; i < 16; i++)
      padIn[i] = padOe[i] ? padOut[i] : (padPullup[i] ? 1'b1 : wander[i]);
endmodule // gpo_pad_model

// *** verification/tb.sv ***
// tb: self-checking bench for the pin override port block
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sleepClamp = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  gpo_pkg::gpo_ovr_t [15:0] ovr = '0;
  logic [15:0] extIntEnable = 16'h0000;
  gpo_pkg::gpo_sense_t [15:0] sense = '{default: gpo_pkg::SENSE_LOW};
  gpo_pkg::gpo_sense_t senses [3] = '{gpo_pkg::SENSE_ANY, gpo_pkg::SENSE_FALL, gpo_pkg::SENSE_RISE};
  logic [15:0] padIn, padOut, padOe, padPullup, rawIn, wakeFlag;
  int n_mismatch = 0;
  int checks = 0;
  initial forever #4 ref_clk = ~ref_clk;
  gpo_port i_dut (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleepClamp(sleepClamp),
    .pinOverride(ovr), .extIntEnable(extIntEnable), .extIntSense(sense), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .padPullup(padPullup), .altfuncRawInput(rawIn), .wakeFlag(wakeFlag), .irq(irq));
  gpo_pad_model i_pad (.ref_clk(ref_clk), .padOut(padOut), .padOe(padOe), .padPullup(padPullup), .padIn(padIn));
  // ****************
  // tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic hung();
    n_mismatch++;
    $display("mismatch bus answer expected response seen none");
    close_out();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 40) hung();
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask
  // mask hides pads that float in the partner model
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
    int k;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 40) hung();
    rready <= 1'b0;
    chk("rdata", rdata & m, exp);
    chk("rresp", rresp, er);
  endtask
  task automatic stp();
    @(posedge ref_clk);
    #1;
  endtask
  // ****************
  // sequence
  // ****************
  initial
  begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int a = 0; a < 40; a += 4)
      rd(a[7:0], 32'h0, (a == 8 || a == 20) ? 32'h0 : 32'hFFFFFFFF, gpo_pkg::RESP_OKAY);
    chk("irq", irq, 1'b0);
    $display("test reset values done");
    wr(gpo_pkg::ADDR_OUT_A, 32'h03, gpo_pkg::RESP_OKAY);
    wr(gpo_pkg::ADDR_DIR_A, 32'h02, gpo_pkg::RESP_OKAY);
    stp();
    chk("pullup", padPullup[2:0], 3'b001);
    chk("oe", padOe[2:0], 3'b010);
    chk("out", padOut[1], 1'b1);
    chk("raw", rawIn[1:0], 2'b11);
    rd(gpo_pkg::ADDR_IN_A, 32'h03, 32'h03, gpo_pkg::RESP_OKAY);
    wr(gpo_pkg::ADDR_MCU_CONTROL, 32'h10, gpo_pkg::RESP_OKAY);
    stp();
    chk("pullup", padPullup[0], 1'b0);
    wr(gpo_pkg::ADDR_MCU_CONTROL, 32'h00, gpo_pkg::RESP_OKAY);
    wr(gpo_pkg::ADDR_OUT_B, 32'h01, gpo_pkg::RESP_OKAY);
    wr(gpo_pkg::ADDR_PORT_CONTROL, 32'h01, gpo_pkg::RESP_OKAY);
    stp();
    chk("pullup", {padPullup[8], padPullup[0]}, 2'b10);
    wr(gpo_pkg::ADDR_PORT_CONTROL, 32'h00, gpo_pkg::RESP_OKAY);
    $display("test pads and pull-ups done");
    wr(gpo_pkg::ADDR_IN_A, 32'h01, gpo_pkg::RESP_OKAY);
    rd(gpo_pkg::ADDR_OUT_A, 32'h02, 32'hFF, gpo_pkg::RESP_OKAY);
    wr(gpo_pkg::ADDR_IN_A, 32'h01, gpo_pkg::RESP_OKAY);
    rd(gpo_pkg::ADDR_OUT_A, 32'h03, 32'hFF, gpo_pkg::RESP_OKAY);
    @(posedge ref_clk);
    ovr[3] <= 9'h1F8;
    @(posedge ref_clk);
    ovr[1].direction_override_en <= 1'b1;
    stp();
    chk("ovr", {padPullup[3], padOe[3], padOut[3], padOe[1]}, 4'b1110);
    @(posedge ref_clk);
    ovr[3] <= 9'h168; // pull-up forced off, value override off, driver still forced on
    stp();
    chk("ovr", {padPullup[3], padOut[3]}, 2'b00);
    @(posedge ref_clk);
    ovr <= '0;
    @(posedge ref_clk);
    ovr[2].output_toggle_override <= 1'b1;
    @(posedge ref_clk);
    ovr[2].output_toggle_override <= 1'b0;
    rd(gpo_pkg::ADDR_OUT_A, 32'h07, 32'hFF, gpo_pkg::RESP_OKAY);
    $display("test toggles and overrides done");
    @(posedge ref_clk);
    sleepClamp <= 1'b1;
    stp();
    chk("raw", rawIn[0], 1'b0);
    @(posedge ref_clk);
    extIntEnable[0] <= 1'b1;
    stp();
    chk("raw", rawIn[0], 1'b1);
    @(posedge ref_clk);
    extIntEnable[0] <= 1'b0;
    ovr[0] <= 9'h003; // input enable override on, value one
    stp();
    chk("raw", rawIn[0], 1'b1);
    @(posedge ref_clk);
    sleepClamp <= 1'b0;
    ovr[0].input_enable_override_val <= 1'b0;
    stp();
    chk("raw", rawIn[0], 1'b0);
    @(posedge ref_clk);
    ovr <= '0;
    $display("test sleep clamp done");
    // pin 0 and pin 1 both sit high; pin 1 keeps the low-level sense and must stay quiet
    foreach (senses[i])
    begin
      @(posedge ref_clk);
      sense[0] <= senses[i];
      sleepClamp <= 1'b1;
      repeat (3) @(posedge ref_clk);
      sleepClamp <= 1'b0;
      repeat (3) stp();
      chk("wake", wakeFlag[1:0], 2'b01);
      chk("irq", irq, 1'b0);
      wr(gpo_pkg::ADDR_IRQ_MASK, 32'h01, gpo_pkg::RESP_OKAY);
      stp();
      chk("irq", irq, 1'b1);
      rd(gpo_pkg::ADDR_IRQ_STATUS, 32'h01, 32'hFFFF, gpo_pkg::RESP_OKAY);
      wr(gpo_pkg::ADDR_IRQ_STATUS, 32'h01, gpo_pkg::RESP_OKAY);
      stp();
      chk("wake", {wakeFlag[0], irq}, 2'b00);
      wr(gpo_pkg::ADDR_IRQ_MASK, 32'h00, gpo_pkg::RESP_OKAY);
    end
    $display("test wake flags done");
    // byte lane 0 strobe low: the write is answered but ignored
    wstrb <= 4'hE;
    wr(gpo_pkg::ADDR_DIR_B, 32'hFF, gpo_pkg::RESP_OKAY);
    rd(gpo_pkg::ADDR_DIR_B, 32'h0, 32'hFF, gpo_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    wr(8'h40, 32'hFF, gpo_pkg::RESP_SLVERR);
    rd(8'h40, 32'h0, 32'hFFFFFFFF, gpo_pkg::RESP_SLVERR);
    @(posedge ref_clk);
    nrst <= 1'b0;
    #1;
    chk("pullup", padPullup, 16'h0000);
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(gpo_pkg::ADDR_OUT_A, 32'h0, 32'hFF, gpo_pkg::RESP_OKAY);
    $display("test unmapped and reset done");
    close_out();
  end
endmodule // tb
